// ### core/eeprom_pkg.sv
// constants for the serial eeprom command front end
package eeprom_pkg;
  // opcodes
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_SR_READ = 8'h05;
  localparam logic [7:0] OP_SR_WRITE = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  // status byte field positions
  localparam int SR_BUSY = 0;
  localparam int SR_LATCH = 1;
  localparam int SR_BP0 = 2;
  localparam int SR_BP1 = 3;
  localparam int SR_LOCK = 4;
  localparam int SR_IDSEL = 6;
  localparam int SR_PINEN = 7;
  localparam logic [7:0] STATUS_RST = 8'h00;
  // geometry
  localparam int ADDR_BITS = 16;
  localparam int ID_PAGE_BYTES = 128;
  localparam int ID_ADDR_BITS = 7;
  // byte slots in a session: opcode, addr hi, addr lo, data
  localparam logic [2:0] SLOT_OP = 3'h0;
  localparam logic [2:0] SLOT_AH = 3'h1;
  localparam logic [2:0] SLOT_AL = 3'h2;
  localparam logic [2:0] SLOT_DAT = 3'h3;
  localparam logic [2:0] SLOT_MAX = 3'h4;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WRITE_CYCLE_TIME_NS = 5000000;
  localparam int WRITE_CYCLE_CNT = WRITE_CYCLE_TIME_NS / CLK_PERIOD_NS;
endpackage

// ### core/sync_two_flop.sv
// two flip-flop level synchroniser
`timescale 1ns/100ps
module sync_two_flop #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // sync_two_flop

// ### core/eeprom_front.sv
// serial eeprom command front end: spi session logic and write engine
`timescale 1ns/100ps
module eeprom_front #(
  parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLE_CNT,
  parameter int AW = eeprom_pkg::ADDR_BITS
) (
  // system clock and reset
  input wire logic REF_CLK,
  input wire logic NRST,
  // serial link
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SI,
  input wire logic HOLD_N,
  input wire logic WP_N,
  output logic SO_O,
  output logic SO_OE,
  // status
  output logic [7:0] STATUS,
  output logic BUSY
);
  localparam int CW = $clog2(WRITE_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(WRITE_CYCLES - 1);

  // arrays: main and id page
  logic [7:0] mem [0:(2**AW)-1];
  logic [7:0] id_mem [0:eeprom_pkg::ID_PAGE_BYTES-1];

  // link domain state
  logic [2:0] bit_reg;
  logic [2:0] slot_reg;
  logic [7:0] shift_reg;
  logic [7:0] opcode_reg;
  logic [7:0] addr_hi_reg;
  logic [7:0] addr_lo_reg;
  logic [7:0] data_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW-1:0] rd_ptr_next;
  logic done_reg;
  logic so_reg;
  logic [7:0] out_sh_reg;
  logic [7:0] out_sh_next;
  logic so_next;
  logic busy_sck;

  // system domain state
  logic sel_s;
  wire cs_s = !sel_s;
  logic wp_s;
  logic done_s;
  logic cs_d_reg;
  logic done_hold_reg;
  logic busy_reg;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic latch_reg;
  logic latch_next;
  logic pinen_reg;
  logic pinen_next;
  logic idsel_reg;
  logic idsel_next;
  logic idlock_reg;
  logic idlock_next;
  logic [1:0] bp_reg;
  logic [1:0] bp_next;
  logic busy_next;

  // opcode decode, shared by both domains
  wire [7:0] in_byte = {shift_reg[6:0], SI};
  wire op_set = opcode_reg == eeprom_pkg::OP_SET_LATCH;
  wire op_clr = opcode_reg == eeprom_pkg::OP_CLR_LATCH;
  wire op_srrd = opcode_reg == eeprom_pkg::OP_SR_READ;
  wire op_srwr = opcode_reg == eeprom_pkg::OP_SR_WRITE;
  wire op_read = opcode_reg == eeprom_pkg::OP_READ;
  wire op_write = opcode_reg == eeprom_pkg::OP_WRITE;
  wire in_set = in_byte == eeprom_pkg::OP_SET_LATCH;
  wire in_clr = in_byte == eeprom_pkg::OP_CLR_LATCH;

  // link side decode
  wire byte_end = HOLD_N && bit_reg == 3'h7;
  wire at_op = slot_reg == eeprom_pkg::SLOT_OP;
  wire at_ah = slot_reg == eeprom_pkg::SLOT_AH;
  wire at_al = slot_reg == eeprom_pkg::SLOT_AL;
  wire in_data = slot_reg >= eeprom_pkg::SLOT_DAT;
  wire ld_op = byte_end && at_op;
  wire ld_ah = byte_end && at_ah;
  wire ld_al = byte_end && at_al;
  wire ld_dat = byte_end && ((at_ah && op_srwr) || (in_data && op_write));
  // a command counts only once its last field is in; unknown bytes never do
  wire fire = byte_end && ((at_op && (in_set || in_clr)) ||
              (at_ah && op_srwr) || (at_al && op_read) ||
              (slot_reg == eeprom_pkg::SLOT_DAT && op_write));
  wire out_phase = (op_srrd && !at_op) ||
                   (op_read && in_data && !busy_sck);
  wire load_out = out_phase && bit_reg == 3'h0;
  wire [7:0] mem_byte = idsel_reg ?
    id_mem[rd_ptr_reg[eeprom_pkg::ID_ADDR_BITS-1:0]] : mem[rd_ptr_reg];
  wire [7:0] out_byte = op_srrd ? {STATUS[7:1], busy_sck} : mem_byte;

  // slot counters clear at deselect so each low period is one session
  always_ff @(posedge SCK or posedge CS_N) begin
    if (CS_N) begin
      bit_reg <= 3'h0;
      slot_reg <= eeprom_pkg::SLOT_OP;
    end else if (HOLD_N) begin
      bit_reg <= bit_reg + 3'h1;
      if (byte_end && slot_reg != eeprom_pkg::SLOT_MAX) begin
        slot_reg <= slot_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge SCK or posedge CS_N) begin
    if (CS_N) begin
      done_reg <= 1'b0;
    end else if (fire) begin
      done_reg <= 1'b1;
    end
  end

  // field registers keep their value after deselect for the write engine
  always_ff @(posedge SCK) begin
    if (HOLD_N) begin
      shift_reg <= in_byte;
    end
  end

  always_ff @(posedge SCK) begin
    if (ld_op) begin
      opcode_reg <= in_byte;
    end
  end

  always_ff @(posedge SCK) begin
    if (ld_ah) begin
      addr_hi_reg <= in_byte;
    end
    if (ld_al) begin
      addr_lo_reg <= in_byte;
    end
    if (ld_dat) begin
      data_reg <= in_byte;
    end
  end

  // a narrow array drops the upper address bits on purpose
  assign rd_ptr_next = ld_al ? AW'({addr_hi_reg, in_byte}) :
                       rd_ptr_reg + AW'(1);
  always_ff @(posedge SCK) begin
    if (ld_al || (byte_end && in_data && op_read)) begin
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // output shifter on the falling edge gives the host a full half period
  assign so_next = load_out ? out_byte[7] : out_sh_reg[7];
  assign out_sh_next = load_out ? {out_byte[6:0], 1'b0} :
                       {out_sh_reg[6:0], 1'b0};
  always_ff @(negedge SCK or posedge CS_N) begin
    if (CS_N) begin
      so_reg <= 1'b0;
      out_sh_reg <= 8'h00;
    end else if (HOLD_N) begin
      so_reg <= so_next;
      out_sh_reg <= out_sh_next;
    end
  end

  assign SO_O = so_reg;
  assign SO_OE = !CS_N && HOLD_N && out_phase;

  // busy into the link domain; other status bits move at deselect, but the latch also clears when the internal write ends
  sync_two_flop #(.W(1)) u_sck_sync (
    .clk(SCK),
    .rst_n(1'b1),
    .d(busy_reg),
    .q(busy_sck)
  );

  // select enters inverted: a synchroniser in reset reads as deselected,
  // so no false select edge follows reset
  sync_two_flop #(.W(3)) u_ref_sync (
    .clk(REF_CLK),
    .rst_n(NRST),
    .d({!CS_N, WP_N, done_reg}),
    .q({sel_s, wp_s, done_s})
  );

  // done is caught while selected since it clears with chip select
  wire cs_rise = cs_s && !cs_d_reg;
  wire exec = cs_rise && done_hold_reg && !busy_reg;
  wire sr_locked = !wp_s && pinen_reg;
  wire sr_ok = exec && op_srwr && latch_reg && !sr_locked;
  wire both_set = data_reg[eeprom_pkg::SR_IDSEL] &&
                  data_reg[eeprom_pkg::SR_LOCK];
  wire wr_ok = exec && op_write && latch_reg &&
               !(idsel_reg && idlock_reg);
  wire mem_op = exec && (op_write || op_read);
  wire busy_end = busy_reg && cnt_reg == CNT_LAST;

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      cs_d_reg <= 1'b1;
      done_hold_reg <= 1'b0;
    end else begin
      cs_d_reg <= cs_s;
      if (!cs_s) begin
        done_hold_reg <= done_s;
      end
    end
  end

  assign busy_next = (busy_reg && !busy_end) || sr_ok || wr_ok;
  // counter returns to zero with the last busy cycle
  assign cnt_next = (busy_reg && !busy_end) ? cnt_reg + CW'(1) : '0;
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      busy_reg <= eeprom_pkg::STATUS_RST[eeprom_pkg::SR_BUSY];
      cnt_reg <= '0;
    end else begin
      busy_reg <= busy_next;
      cnt_reg <= cnt_next;
    end
  end

  assign latch_next = busy_end ? 1'b0 :
                      (exec && op_set) ? 1'b1 :
                      (exec && op_clr) ? 1'b0 : latch_reg;
  assign pinen_next = sr_ok ? data_reg[eeprom_pkg::SR_PINEN] : pinen_reg;
  assign bp_next = sr_ok ? data_reg[eeprom_pkg::SR_BP1:eeprom_pkg::SR_BP0] :
                   bp_reg;
  // select and lock together are refused, both bits stay as they were
  assign idsel_next = (sr_ok && !both_set) ?
                      data_reg[eeprom_pkg::SR_IDSEL] :
                      mem_op ? 1'b0 : idsel_reg;
  assign idlock_next = idlock_reg ||
                       (sr_ok && !both_set &&
                        data_reg[eeprom_pkg::SR_LOCK]);
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      latch_reg <= eeprom_pkg::STATUS_RST[eeprom_pkg::SR_LATCH];
      pinen_reg <= eeprom_pkg::STATUS_RST[eeprom_pkg::SR_PINEN];
      idsel_reg <= eeprom_pkg::STATUS_RST[eeprom_pkg::SR_IDSEL];
      idlock_reg <= eeprom_pkg::STATUS_RST[eeprom_pkg::SR_LOCK];
      bp_reg <= eeprom_pkg::STATUS_RST[eeprom_pkg::SR_BP1:eeprom_pkg::SR_BP0];
    end else begin
      latch_reg <= latch_next;
      pinen_reg <= pinen_next;
      idsel_reg <= idsel_next;
      idlock_reg <= idlock_next;
      bp_reg <= bp_next;
    end
  end

  // array is written once at deselect; the link only reads it when idle
  always_ff @(posedge REF_CLK) begin
    if (wr_ok && !idsel_reg) begin
      mem[AW'({addr_hi_reg, addr_lo_reg})] <= data_reg;
    end
    if (wr_ok && idsel_reg) begin
      id_mem[addr_lo_reg[eeprom_pkg::ID_ADDR_BITS-1:0]] <= data_reg;
    end
  end

  assign STATUS = {pinen_reg, idsel_reg, 1'b0, idlock_reg, bp_reg, latch_reg,
                   busy_reg};
  assign BUSY = busy_reg;

  // checks, system domain
  sequence s_exec_clr;
    exec && op_clr;
  endsequence
  sequence s_exec_set;
    exec && op_set;
  endsequence

  a_latch_set: assert property (@(posedge REF_CLK) disable iff (!NRST)
    s_exec_set |=> latch_reg)
    else $error("write latch not set by set command");
  a_latch_clear: assert property (@(posedge REF_CLK) disable iff (!NRST)
    s_exec_clr |=> !latch_reg)
    else $error("write latch not cleared by clear command");
  a_write_needs_latch: assert property (@(posedge REF_CLK) disable iff (!NRST)
    $rose(busy_reg) |-> $past(latch_reg) && $past(cs_rise))
    else $error("internal write started without latch or deselect");
  a_sr_protect: assert property (@(posedge REF_CLK) disable iff (!NRST)
    exec && op_srwr && !wp_s && pinen_reg |=>
    !busy_reg && $stable(bp_reg))
    else $error("status write accepted while pin protected");
  a_pin_high_free: assert property (@(posedge REF_CLK) disable iff (!NRST)
    exec && op_srwr && latch_reg && wp_s |=> busy_reg)
    else $error("status write refused with protect pin high");
  a_busy_ignore: assert property (@(posedge REF_CLK) disable iff (!NRST)
    busy_reg && !busy_end && cs_rise |=> $stable(latch_reg) && busy_reg)
    else $error("command acted on during internal write");
  a_write_end: assert property (@(posedge REF_CLK) disable iff (!NRST)
    busy_end |=> !busy_reg && !latch_reg && cnt_reg == '0)
    else $error("internal write did not end on time");
  a_busy_bound: assert property (@(posedge REF_CLK) disable iff (!NRST)
    busy_reg |-> cnt_reg <= CNT_LAST)
    else $error("internal write ran past its cycle count");
  a_id_lock: assert property (@(posedge REF_CLK) disable iff (!NRST)
    exec && op_write && idsel_reg && idlock_reg |=> !busy_reg)
    else $error("write to locked id page accepted");
  a_lock_sticky: assert property (@(posedge REF_CLK) disable iff (!NRST)
    idlock_reg |=> idlock_reg)
    else $error("id page lock was released");
  a_idsel_clear: assert property (@(posedge REF_CLK) disable iff (!NRST)
    mem_op |=> !idsel_reg)
    else $error("id page select kept after memory access");
  a_so_hiz: assert property (@(posedge REF_CLK) disable iff (!NRST)
    CS_N |-> !SO_OE)
    else $error("serial output driven while deselected");

  // checks, link domain
  a_unknown_op: assert property (@(posedge SCK) disable iff (CS_N)
    ld_op && !(in_set || in_clr) |=> !done_reg)
    else $error("unknown opcode counted as command");
  a_hold_freeze: assert property (@(posedge SCK) disable iff (CS_N)
    !HOLD_N |=> $stable(bit_reg) && $stable(shift_reg))
    else $error("transfer state moved while paused");
endmodule // eeprom_front

// ### test/spi_host_model.sv
// host spi controller model, mode 0, facing the eeprom link
`timescale 1ns/100ps
module spi_host_model (
  // link lines driven by the host
  output logic sck,
  output logic cs_n,
  output logic si,
  output logic hold_n,
  // device reply
  input wire logic so_o,
  input wire logic so_oe
);
  logic so_last;
  logic held_oe;
  wire logic line;
  // released line shows no stale bit: inverse of the last driven value
  assign line = so_oe ? so_o : ~so_last;
  always @(so_o or so_oe) if (so_oe) so_last = so_o;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
    so_last = 1'b0;
    held_oe = 1'b0;
  end
  // clock idles low between sessions; odd delay keeps phase unrelated
  task open_s;
    #37 cs_n = 1'b0;
    #50;
  endtask
  task close_s;
    #60 cs_n = 1'b1;
    #120;
  endtask
  // one byte msb first; si set while clock low, reply taken on rise
  task xb(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    int i;
    rx = 8'h00;
    for (i = 7; i > 7 - nb; i--) begin
      si = tx[i];
      #80 sck = 1'b1;
      rx[i] = line;
      #80 sck = 1'b0;
    end
  endtask
  // pause with the clock low at both hold edges
  task pause;
    #40 hold_n = 1'b0;
    #100 held_oe = so_oe;
    #100 hold_n = 1'b1;
    #40;
  endtask
endmodule // spi_host_model

// ### test/eeprom_front_tb_top.sv
// self-checking bench for the eeprom command front end
`timescale 1ns/100ps
module eeprom_front_tb_top;
  // short write cycle keeps the run small
  localparam int WC = 2000;
  logic ref_clk;
  logic nrst;
  logic wp_n;
  wire logic sck;
  wire logic cs_n;
  wire logic si;
  wire logic hold_n;
  wire logic so_o;
  wire logic so_oe;
  wire logic busy;
  wire logic [7:0] status;
  int err_total;
  int checks_done;
  int n;
  logic [7:0] rd;
  always #5 ref_clk = ~ref_clk;
  spi_host_model i_spi_host_model (.sck(sck), .cs_n(cs_n), .si(si),
    .hold_n(hold_n), .so_o(so_o), .so_oe(so_oe));
  eeprom_front #(.WRITE_CYCLES(WC), .AW(8)) i_eeprom_front (
    .REF_CLK(ref_clk), .NRST(nrst), .SCK(sck), .CS_N(cs_n), .SI(si),
    .HOLD_N(hold_n), .WP_N(wp_n), .SO_O(so_o), .SO_OE(so_oe),
    .STATUS(status), .BUSY(busy));
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task conclude;
    if (err_total == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // one session of nbit bits from b, top byte first; rx is last byte
  task sess(input logic [31:0] b, input int nbit, input bit hp,
            output logic [7:0] rx);
    int k;
    int w;
    i_spi_host_model.open_s();
    for (k = 0; 8 * k < nbit; k++) begin
      w = (nbit - 8 * k > 8) ? 8 : nbit - 8 * k;
      if (hp && k == 3) i_spi_host_model.pause();
      i_spi_host_model.xb(b[31-8*k -: 8], w, rx);
    end
    i_spi_host_model.close_s();
  endtask
  // let the command land, then wait out any internal write
  task settle;
    int i;
    repeat (10) @(posedge ref_clk);
    for (i = 0; i < 3 * WC && busy === 1'b1; i++) @(posedge ref_clk);
    if (busy !== 1'b0) begin
      err_total++;
      conclude();
    end
  endtask
  // a refused command must not start an internal write
  task quiet;
    repeat (10) @(posedge ref_clk);
    cmp(busy, 1'b0);
  endtask
  task set_latch;
    sess({eeprom_pkg::OP_SET_LATCH, 24'h0}, 8, 1'b0, rd);
    settle();
  endtask
  task sr_wr(input logic [7:0] v);
    set_latch();
    sess({eeprom_pkg::OP_SR_WRITE, v, 16'h0}, 16, 1'b0, rd);
    settle();
  endtask
  task mem_wr(input logic [7:0] a, input logic [7:0] d);
    set_latch();
    sess({eeprom_pkg::OP_WRITE, 8'h00, a, d}, 32, 1'b0, rd);
    settle();
  endtask
  task mem_rd(input logic [7:0] a, input bit hp, output logic [7:0] d);
    sess({eeprom_pkg::OP_READ, 8'h00, a, 8'h00}, 32, hp, d);
    settle();
  endtask
  task busy_len(output int nb);
    int i;
    nb = 0;
    for (i = 0; i < 3 * WC; i++) begin
      @(posedge ref_clk);
      if (busy === 1'b1) nb++;
      else if (nb > 0) break;
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    wp_n = 1'b1;
    err_total = 0;
    checks_done = 0;
    repeat (10) @(posedge ref_clk);
    #1 nrst = 1'b1;
    repeat (6) @(posedge ref_clk);
    cmp({busy, status}, 16'h00);
    sess({eeprom_pkg::OP_WRITE, 24'h001255}, 32, 1'b0, rd);
    quiet();
    set_latch();
    cmp(status, 16'h02);
    sess(32'h0A00_1255, 32, 1'b0, rd);
    quiet();
    sess({eeprom_pkg::OP_CLR_LATCH, 24'h0}, 8, 1'b0, rd);
    settle();
    cmp(status, 16'h00);
    // byte write, status polled while the internal write runs
    set_latch();
    fork
      busy_len(n);
      begin
        sess({eeprom_pkg::OP_WRITE, 24'h0012A5}, 32, 1'b0, rd);
        repeat (10) @(posedge ref_clk);
        sess({eeprom_pkg::OP_SR_READ, 24'h0}, 16, 1'b0, rd);
        cmp(rd, 16'h03);
      end
    join
    cmp(n >= WC - 1 && n <= WC + 1, 1'b1);
    settle();
    cmp(status, 16'h00);
    set_latch();
    sess({eeprom_pkg::OP_WRITE, 24'h00125A}, 28, 1'b0, rd);
    quiet();
    mem_rd(8'h12, 1'b1, rd);
    cmp(i_spi_host_model.held_oe, 1'b0);
    cmp(rd, 16'hA5);
    cmp(so_oe, 1'b0);
    sr_wr(8'h80);
    cmp(status, 16'h80);
    @(posedge ref_clk);
    #1 wp_n = 1'b0;
    sr_wr(8'h84);
    cmp(status[7:2], 16'h20);
    @(posedge ref_clk);
    #1 wp_n = 1'b1;
    sr_wr(8'h04);
    sess({eeprom_pkg::OP_SR_READ, 24'h0}, 16, 1'b0, rd);
    cmp(rd, 16'h04);
    sr_wr(8'h40);
    cmp(status[6], 1'b1);
    mem_wr(8'h12, 8'h3C);
    mem_rd(8'h12, 1'b0, rd);
    cmp(rd, 16'hA5);
    sr_wr(8'h40);
    mem_rd(8'h12, 1'b0, rd);
    cmp(rd, 16'h3C);
    sr_wr(8'h10);
    sr_wr(8'h40);
    mem_wr(8'h12, 8'h77);
    sr_wr(8'h40);
    mem_rd(8'h12, 1'b0, rd);
    cmp(rd, 16'h3C);
    cmp(status[4], 1'b1);
    conclude();
  end
endmodule // eeprom_front_tb_top
